// ---- rtl/fic_controller.sv ----
// flash programming command controller: registers, checks, operation sequencer
// How it works
// - fail flag on disabled application self-update, loader self-update or bad address
// - writing 1 clears the fail flag, writing 0 leaves it
// - loader updates from application only while its update enable is 1
// - configuration updates from either area only while its enable is 1
// - application self-update only while its update enable is 1
// - boot select picks next boot; power-on loads inverted config boot bit
// - operations run only while programming is enabled
// - program uses data register; a read returns its word there
// - six-bit command decodes read, unique-ID read, program, page erase
// - trigger reads 1 while busy, cleared by hardware when done
// - data-area base reads 0x0001_F000 and is read-only
// - low-frequency optimisation bit enables the slow-clock access mode
// - config clock-filter bit: 0 disables, 1 enables the crystal filter
// - config clock source: 000 crystal, 111 internal RC oscillator
// - a trigger with an error starts nothing and sets the fail flag
`timescale 1ns/100ps
`default_nettype none
module fic_controller
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    power_on_reset,
    // register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic [31:0]                  reg_rdata,
    // system state
    input  wire logic                    write_unlocked,
    input  wire logic                    running_in_loader,
    input  wire logic [31:0]             config_word,
    // flash macro
    output fic_pkg::fic_flash_req_s      flash_req,
    output logic                         flash_start,
    input  wire logic                    flash_done,
    input  wire logic [31:0]             flash_rdata,
    // decoded settings
    output logic                         boot_select,
    output logic                         low_frequency_optimisation,
    output fic_pkg::fic_cfg_out_s        cfg_out
);
    import fic_pkg::*;

    typedef enum logic [1:0] {FIC_ST_IDLE, FIC_ST_CHECK, FIC_ST_RUN} fic_state_e;
    localparam logic [31:0] FIC_CTL_STORED = FIC_CTL_WMASK & ~(32'h1 << FIC_CTL_BOOT);

    logic [31:0] control;
    logic        fail_flag;
    logic [31:0] programming_address;
    logic [31:0] programming_data;
    logic [5:0]  programming_command;
    logic        start_trigger;
    logic [31:0] access_time_control;
    fic_state_e  state;
    fic_op_e     cur_op;
    logic        cur_error;
    logic        boot_loaded;

    // decode the command field
    function automatic fic_op_e decode_cmd(input logic [5:0] c);
        case (c)
            FIC_CMD_READ:  decode_cmd = FIC_OP_READ;
            FIC_CMD_UID:   decode_cmd = FIC_OP_UID;
            FIC_CMD_PROG:  decode_cmd = FIC_OP_PROG;
            FIC_CMD_ERASE: decode_cmd = FIC_OP_ERASE;
            default:       decode_cmd = FIC_OP_NONE;
        endcase
    endfunction

    function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // error check of the pending operation, evaluated from registers
    logic in_app, in_data, in_ldr, in_cfg, is_update, next_error;
    always_comb begin
        in_app    = programming_address <= FIC_APP_END;
        in_data   = in_rng(programming_address, FIC_DATA_START, FIC_DATA_END);
        in_ldr    = in_rng(programming_address, FIC_LDR_START, FIC_LDR_END);
        in_cfg    = in_rng(programming_address, FIC_CFG_START, FIC_CFG_END);
        is_update = (cur_op == FIC_OP_PROG) || (cur_op == FIC_OP_ERASE);
        next_error = 1'b0;
        if (cur_op == FIC_OP_NONE || !control[FIC_CTL_EN]) begin
            next_error = 1'b1;
        end else if (cur_op != FIC_OP_UID && !(in_app || in_data || in_ldr || in_cfg)) begin
            next_error = 1'b1;
        end else if (is_update && in_app && !running_in_loader
                     && !control[FIC_CTL_APPLICATION_UPDATE_ENABLE]) begin
            next_error = 1'b1;
        end else if (is_update && in_ldr && running_in_loader) begin
            next_error = 1'b1;
        end else if (is_update && in_ldr && !control[FIC_CTL_LOADER_UPDATE_ENABLE]) begin
            next_error = 1'b1;
        end else if (is_update && in_cfg && !control[FIC_CTL_CFGEN]) begin
            next_error = 1'b1;
        end
    end

    logic wr_ctl, wr_trg, wr_atm;
    assign wr_ctl = reg_write && reg_addr == FIC_OFS_CONTROL;
    assign wr_trg = reg_write && reg_addr == FIC_OFS_TRIGGER && write_unlocked;
    assign wr_atm = reg_write && reg_addr == FIC_OFS_ATIME && write_unlocked;

    ////////////////////////////////////////////////////////////////////////////
    // protected control bits, boot select kept through ordinary resets
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            control <= FIC_RST_WORD;
        end else if (wr_ctl && write_unlocked) begin
            control <= reg_wdata & FIC_CTL_STORED; // boot and fail bits live apart
        end
    end

    // boot select: only power-on reloads it, so a software reset keeps it
    always_ff @(posedge clk_sys) begin
        if (power_on_reset) begin
            boot_loaded <= 1'b0;
        end else begin
            boot_loaded <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (power_on_reset) begin
            boot_select <= 1'b0;
        end else if (!boot_loaded) begin
            boot_select <= ~config_word[FIC_CFG_CBS];
        end else if (wr_ctl && write_unlocked) begin
            boot_select <= reg_wdata[FIC_CTL_BOOT];
        end
    end

    // fail flag: hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fail_flag <= 1'b0;
        end else if (state == FIC_ST_CHECK && next_error) begin
            fail_flag <= 1'b1;
        end else if (wr_ctl && reg_wdata[FIC_CTL_FAIL]) begin
            fail_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address, command and access-time registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            programming_address <= FIC_RST_WORD;
            programming_command <= '0;
            access_time_control <= FIC_ATIME_RST;
        end else begin
            if (reg_write && reg_addr == FIC_OFS_ADDRESS) begin
                programming_address <= reg_wdata;
            end
            if (reg_write && reg_addr == FIC_OFS_COMMAND) begin
                programming_command <= reg_wdata[5:0];
            end
            if (wr_atm) begin
                access_time_control <= (access_time_control & ~FIC_ATIME_MASK)
                                     | (reg_wdata & FIC_ATIME_MASK);
            end
        end
    end
    assign low_frequency_optimisation = access_time_control[FIC_ATM_LOW_FREQUENCY_OPTIMISATION];

    // data register: software write or read-back from the array
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            programming_data <= FIC_RST_WORD;
        end else if (state == FIC_ST_RUN && flash_done
                     && (cur_op == FIC_OP_READ || cur_op == FIC_OP_UID)) begin
            programming_data <= flash_rdata;
        end else if (reg_write && reg_addr == FIC_OFS_DATA) begin
            programming_data <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: trigger latches command, one cycle check, then run to done
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state         <= FIC_ST_IDLE;
            start_trigger <= 1'b0;
            cur_op        <= FIC_OP_NONE;
        end else begin
            case (state)
                FIC_ST_IDLE: begin
                    if (wr_trg && reg_wdata[FIC_TRG_GO]) begin
                        start_trigger <= 1'b1;
                        cur_op        <= decode_cmd(programming_command);
                        state         <= FIC_ST_CHECK;
                    end
                end
                FIC_ST_CHECK: begin
                    if (next_error) begin
                        start_trigger <= 1'b0;
                        state         <= FIC_ST_IDLE;
                    end else begin
                        state <= FIC_ST_RUN;
                    end
                end
                FIC_ST_RUN: begin
                    if (flash_done) begin
                        start_trigger <= 1'b0;
                        state         <= FIC_ST_IDLE;
                    end
                end
                default: begin
                    state <= FIC_ST_IDLE;
                end
            endcase
        end
    end

    // request to the macro, captured in the check cycle; start pulsed only if the check passes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flash_start <= 1'b0;
            flash_req   <= '0;
        end else begin
            flash_start <= state == FIC_ST_CHECK && !next_error;
            if (state == FIC_ST_CHECK) begin
                flash_req.op       <= cur_op;
                flash_req.addr     <= programming_address;
                flash_req.wdata    <= programming_data;
                flash_req.low_freq <= low_frequency_optimisation;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration word decode
    always_comb begin
        cfg_out.clock_filter_en    = config_word[FIC_CFG_CKF];
        cfg_out.osc_xtal           = config_word[FIC_CFG_OSC_LO +: 3] == FIC_OSC_XTAL;
        cfg_out.osc_irc            = config_word[FIC_CFG_OSC_LO +: 3] == FIC_OSC_IRC;
        cfg_out.brownout_detect_on = !config_word[FIC_CFG_BODEN];
        cfg_out.brownout_reset_on  = !config_word[FIC_CFG_BORST];
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the read strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (reset || !reg_read) begin
            reg_rdata <= FIC_RST_WORD;
        end else if (reg_addr == FIC_OFS_CONTROL) begin
            reg_rdata <= control | (32'(boot_select) << FIC_CTL_BOOT)
                       | (32'(fail_flag) << FIC_CTL_FAIL);
        end else if (reg_addr == FIC_OFS_ADDRESS) begin
            reg_rdata <= programming_address;
        end else if (reg_addr == FIC_OFS_DATA) begin
            reg_rdata <= programming_data;
        end else if (reg_addr == FIC_OFS_COMMAND) begin
            reg_rdata <= {26'h0, programming_command};
        end else if (reg_addr == FIC_OFS_TRIGGER) begin
            reg_rdata <= {31'h0, start_trigger};
        end else if (reg_addr == FIC_OFS_DBASE) begin
            reg_rdata <= FIC_DBASE_ADDR;
        end else if (reg_addr == FIC_OFS_ATIME) begin
            reg_rdata <= access_time_control & FIC_ATIME_MASK;
        end else if (reg_addr == FIC_OFS_CONFIG) begin
            reg_rdata <= config_word;
        end else begin
            reg_rdata <= FIC_RST_WORD;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fic_pkg.sv ----
// constants, types and register map of the flash programming command controller
package fic_pkg;
    // register byte offsets
    localparam logic [7:0] FIC_OFS_CONTROL = 8'h00;
    localparam logic [7:0] FIC_OFS_ADDRESS = 8'h04;
    localparam logic [7:0] FIC_OFS_DATA    = 8'h08;
    localparam logic [7:0] FIC_OFS_COMMAND = 8'h0C;
    localparam logic [7:0] FIC_OFS_TRIGGER = 8'h10;
    localparam logic [7:0] FIC_OFS_DBASE   = 8'h14;
    localparam logic [7:0] FIC_OFS_ATIME   = 8'h18;
    localparam logic [7:0] FIC_OFS_CONFIG  = 8'h1C;

    // programming_control, trigger and access-time field positions
    localparam int FIC_CTL_EN    = 0;
    localparam int FIC_CTL_BOOT  = 1;
    localparam int FIC_CTL_APPLICATION_UPDATE_ENABLE = 3;
    localparam int FIC_CTL_CFGEN = 4;
    localparam int FIC_CTL_LOADER_UPDATE_ENABLE = 5;
    localparam int FIC_CTL_FAIL  = 6;
    localparam int FIC_TRG_GO    = 0;
    localparam int FIC_ATM_LOW_FREQUENCY_OPTIMISATION  = 4;

    // configuration word field positions
    localparam int FIC_CFG_CBS    = 7;
    localparam int FIC_CFG_BORST  = 20;
    localparam int FIC_CFG_BODEN  = 23;
    localparam int FIC_CFG_OSC_LO = 24;
    localparam int FIC_CFG_CKF    = 28;

    // clock source codes
    localparam logic [2:0] FIC_OSC_XTAL = 3'h0;
    localparam logic [2:0] FIC_OSC_IRC  = 3'h7;

    // reset values and fixed values
    localparam logic [31:0] FIC_RST_WORD   = 32'h0000_0000;
    localparam logic [31:0] FIC_DBASE_ADDR = 32'h0001_F000;
    localparam logic [31:0] FIC_ATIME_RST  = 32'h0000_0080;
    localparam logic [31:0] FIC_ATIME_MASK = 32'h0000_0010;
    localparam logic [31:0] FIC_CTL_WMASK  = 32'h0000_003B;

    // address map (byte addresses)
    localparam logic [31:0] FIC_APP_END    = 32'h0000_FFFF;
    localparam logic [31:0] FIC_DATA_START = 32'h0001_F000;
    localparam logic [31:0] FIC_DATA_END   = 32'h0001_FFFF;
    localparam logic [31:0] FIC_LDR_START  = 32'h0010_0000;
    localparam logic [31:0] FIC_LDR_END    = 32'h0010_0FFF;
    localparam logic [31:0] FIC_CFG_START  = 32'h0030_0000;
    localparam logic [31:0] FIC_CFG_END    = 32'h0030_0003;

    // command codes
    localparam logic [5:0] FIC_CMD_READ  = 6'h00;
    localparam logic [5:0] FIC_CMD_UID   = 6'h04;
    localparam logic [5:0] FIC_CMD_PROG  = 6'h21;
    localparam logic [5:0] FIC_CMD_ERASE = 6'h22;

    // operation kinds
    typedef enum logic [2:0] {
        FIC_OP_NONE,
        FIC_OP_READ,
        FIC_OP_UID,
        FIC_OP_PROG,
        FIC_OP_ERASE
    } fic_op_e;

    // request to the flash macro
    typedef struct packed {
        fic_op_e     op;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        low_freq;
    } fic_flash_req_s;

    // decoded configuration outputs
    typedef struct packed {
        logic       clock_filter_en;
        logic       osc_xtal;
        logic       osc_irc;
        logic       brownout_detect_on;
        logic       brownout_reset_on;
    } fic_cfg_out_s;
endpackage

// ---- testbench/fic_controller_monitor.sv ----
// port checker for the flash programming command controller
`timescale 1ns/100ps
`default_nettype none
module fic_controller_monitor
    import fic_pkg::*;
(
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    reset,
    input wire logic                    power_on_reset,
    // register port
    input wire logic [7:0]              reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_write,
    input wire logic                    reg_read,
    input wire logic [31:0]             reg_rdata,
    // system state
    input wire logic                    write_unlocked,
    input wire logic                    running_in_loader,
    input wire logic [31:0]             config_word,
    // flash macro
    input wire fic_pkg::fic_flash_req_s flash_req,
    input wire logic                    flash_start,
    input wire logic                    flash_done,
    input wire logic [31:0]             flash_rdata,
    // decoded settings
    input wire logic                    boot_select,
    input wire logic                    low_frequency_optimisation,
    input wire fic_pkg::fic_cfg_out_s   cfg_out
);
    logic        sh_en;
    logic [5:0]  sh_cmd;
    logic [31:0] sh_adr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // expected operation for a command code, none for anything undecoded
    function automatic fic_op_e dec(input logic [5:0] c);
        case (c)
            FIC_CMD_READ:  return FIC_OP_READ;
            FIC_CMD_UID:   return FIC_OP_UID;
            FIC_CMD_PROG:  return FIC_OP_PROG;
            FIC_CMD_ERASE: return FIC_OP_ERASE;
            default:       return FIC_OP_NONE;
        endcase
    endfunction
    // shadows of enable, command and address; only the enable is protected
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sh_en  <= 1'b0;
            sh_cmd <= 6'h00;
            sh_adr <= 32'h0000_0000;
        end else if (reg_write) begin
            if (reg_addr == FIC_OFS_CONTROL && write_unlocked) sh_en <= reg_wdata[FIC_CTL_EN];
            if (reg_addr == FIC_OFS_COMMAND) sh_cmd <= reg_wdata[5:0];
            if (reg_addr == FIC_OFS_ADDRESS) sh_adr <= reg_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_dbase_fixed: assert property (
        reg_read && reg_addr == FIC_OFS_DBASE |=> reg_rdata == FIC_DBASE_ADDR)
        else $error("data area base read wrong");
    a_start_single: assert property (flash_start |=> !flash_start)
        else $error("start pulse longer than one cycle");
    a_start_enabled: assert property (flash_start |-> sh_en)
        else $error("start while programming disabled");
    a_op_decode: assert property (
        flash_start |-> flash_req.op == dec(sh_cmd) && flash_req.addr == sh_adr)
        else $error("request differs from command registers");
    a_low_freq_req: assert property (
        flash_start |-> flash_req.low_freq == low_frequency_optimisation)
        else $error("request access mode differs from setting");
    a_lfo_write: assert property (
        reg_write && reg_addr == FIC_OFS_ATIME && write_unlocked
        |=> low_frequency_optimisation == $past(reg_wdata[FIC_ATM_LOW_FREQUENCY_OPTIMISATION]))
        else $error("optimisation bit not taken from write");
    a_lfo_locked: assert property (
        reg_write && reg_addr == FIC_OFS_ATIME && !write_unlocked
        |=> $stable(low_frequency_optimisation)) else $error("locked write changed mode");
    a_trig_locked: assert property (
        reg_write && reg_addr == FIC_OFS_TRIGGER && !write_unlocked && !flash_start
        |=> !flash_start [*3]) else $error("locked trigger started an operation");
    a_boot_power_on: assert property (
        $fell(power_on_reset) |=> boot_select == !$past(config_word[FIC_CFG_CBS]))
        else $error("boot select not loaded at power-on");
    a_boot_kept: assert property (disable iff (power_on_reset)
        reset && $past(reset) && !$past(power_on_reset) |-> $stable(boot_select))
        else $error("plain reset changed boot select");
    a_cfg_decode: assert property (
        cfg_out == {config_word[FIC_CFG_CKF], config_word[26:24] == FIC_OSC_XTAL,
        config_word[26:24] == FIC_OSC_IRC, !config_word[FIC_CFG_BODEN],
        !config_word[FIC_CFG_BORST]}) else $error("configuration decode wrong");
endmodule
bind fic_controller fic_controller_monitor u_monitor (
    .clk_sys(clk_sys), .reset(reset), .power_on_reset(power_on_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .write_unlocked(write_unlocked),
    .running_in_loader(running_in_loader), .config_word(config_word),
    .flash_req(flash_req), .flash_start(flash_start), .flash_done(flash_done),
    .flash_rdata(flash_rdata), .boot_select(boot_select),
    .low_frequency_optimisation(low_frequency_optimisation), .cfg_out(cfg_out)
);
`default_nettype wire

// ---- testbench/fic_flash_model.sv ----
// behavioural flash array answering the controller's requests
`timescale 1ns/100ps
`default_nettype none
module fic_flash_model
    import fic_pkg::*;
#(
    parameter logic [31:0] UID_BASE = 32'h5A00_0000 // arbitrary value
)
(
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    reset,
    // request side
    input wire fic_pkg::fic_flash_req_s flash_req,
    input wire logic                    flash_start,
    input wire logic                    slow_answer,
    // answer side
    output logic                        flash_done,
    output logic [31:0]                 flash_rdata
);
    logic [31:0]    mem [16];
    fic_flash_req_s req;
    logic           busy;
    logic [3:0]     wait_cnt;
    // one word per index; erase wipes the whole small array like a page
    always_ff @(posedge clk_sys) begin
        flash_done  <= 1'b0;
        flash_rdata <= ~flash_rdata; // idle data toggles so a stale word never looks valid
        if (reset) begin
            busy        <= 1'b0;
            flash_rdata <= 32'h0000_0000;
        end else if (flash_start) begin
            busy     <= 1'b1;
            req      <= flash_req;
            wait_cnt <= slow_answer ? 4'h6 : 4'h1;
        end else if (busy && wait_cnt > 4'h1) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (busy) begin
            busy       <= 1'b0;
            flash_done <= 1'b1;
            case (req.op)
                FIC_OP_READ:  flash_rdata <= mem[req.addr[5:2]];
                FIC_OP_UID:   flash_rdata <= UID_BASE | req.addr;
                FIC_OP_PROG:  mem[req.addr[5:2]] <= req.wdata;
                FIC_OP_ERASE: for (int k = 0; k < 16; k++) mem[k] <= 32'hFFFF_FFFF;
                default:      busy <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- testbench/test_fic_controller.sv ----
// register-level testbench for the flash programming command controller
`timescale 1ns/100ps
`default_nettype none
module test_fic_controller;
    import fic_pkg::*;
    localparam logic [31:0] UID_BASE = 32'h5A00_0000; // arbitrary value
    logic           clk_sys, reset, power_on_reset, reg_write, reg_read, write_unlocked;
    logic           running_in_loader, flash_start, flash_done, boot_select, lfo, slow_answer;
    logic [7:0]     reg_addr;
    logic [31:0]    reg_wdata, reg_rdata, config_word, flash_rdata, v;
    fic_flash_req_s flash_req;
    fic_cfg_out_s   cfg_out;
    int             error_cnt = 0;
    int             checks_done = 0;
    fic_controller dut (.clk_sys(clk_sys), .reset(reset), .power_on_reset(power_on_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .write_unlocked(write_unlocked),
        .running_in_loader(running_in_loader), .config_word(config_word),
        .flash_req(flash_req), .flash_start(flash_start), .flash_done(flash_done),
        .flash_rdata(flash_rdata), .boot_select(boot_select),
        .low_frequency_optimisation(lfo), .cfg_out(cfg_out));
    fic_flash_model #(.UID_BASE(UID_BASE)) u_flash (.clk_sys(clk_sys), .reset(reset),
        .flash_req(flash_req), .flash_start(flash_start), .slow_answer(slow_answer),
        .flash_done(flash_done), .flash_rdata(flash_rdata));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe for one cycle; read data taken at the following edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic start_op(input logic [5:0] c, input logic [31:0] a, input logic [31:0] d);
        wr(FIC_OFS_COMMAND, {26'h0, c});
        wr(FIC_OFS_ADDRESS, a);
        wr(FIC_OFS_DATA, d);
        wr(FIC_OFS_TRIGGER, 32'h1);
    endtask
    // polls the trigger bit under a bound; running out ends the run
    task automatic wait_done;
        logic [31:0] t;
        int          n;
        for (n = 0; n < 40; n++) begin
            rd(FIC_OFS_TRIGGER, t);
            if (t[FIC_TRG_GO] === 1'b0) break;
        end
        if (n == 40) begin
            chk(t, 32'h0);
            final_report();
        end
    endtask
    task automatic run_op(input logic [5:0] c, input logic [31:0] a, input logic [31:0] d);
        start_op(c, a, d);
        wait_done();
    endtask
    // one permission case: fail flag, then write-0 keeps it and write-1 clears it
    task automatic err_case(input logic [7:0] ctl, input logic ld, input logic [5:0] c,
        input logic [31:0] a, input logic fail);
        running_in_loader <= ld;
        wr(FIC_OFS_CONTROL, {24'h0, ctl});
        run_op(c, a, 32'h1234_5678);
        wr(FIC_OFS_CONTROL, {24'h0, ctl});
        rd(FIC_OFS_CONTROL, v);
        chk(v[FIC_CTL_FAIL], fail);
        wr(FIC_OFS_CONTROL, {24'h0, ctl | 8'h40});
        rd(FIC_OFS_CONTROL, v);
        chk(v[FIC_CTL_FAIL], 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, power_on_reset, write_unlocked} = 3'b111;
        {reg_write, reg_read, running_in_loader, slow_answer} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        config_word = 32'h0000_0080;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        @(posedge clk_sys);
        wr(8'h40, 32'hFFFF_FFFF);
        wr(FIC_OFS_DBASE, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), v);
            chk(v, (i == 5) ? FIC_DBASE_ADDR : FIC_RST_WORD);
        end
        chk(boot_select, 1'b0);
        $display("test reset_values done");
        write_unlocked <= 1'b0;
        wr(FIC_OFS_CONTROL, 32'h3B);
        wr(FIC_OFS_ATIME, 32'h10);
        wr(FIC_OFS_TRIGGER, 32'h1);
        rd(FIC_OFS_CONTROL, v);
        chk(v, 32'h0);
        rd(FIC_OFS_TRIGGER, v);
        chk(v, 32'h0);
        chk(lfo, 1'b0);
        write_unlocked <= 1'b1;
        $display("test write_protection done");
        wr(FIC_OFS_CONTROL, 32'h39);
        wr(FIC_OFS_ATIME, 32'h10);
        chk(lfo, 1'b1);
        run_op(FIC_CMD_PROG, 32'h100, 32'hCAFE_1234);
        run_op(FIC_CMD_READ, 32'h100, 32'h0);
        rd(FIC_OFS_DATA, v);
        chk(v, 32'hCAFE_1234);
        slow_answer <= 1'b1;
        start_op(FIC_CMD_ERASE, 32'h100, 32'h0);
        rd(FIC_OFS_TRIGGER, v);
        chk(v, 32'h1);
        wait_done();
        run_op(FIC_CMD_READ, 32'h100, 32'h0);
        rd(FIC_OFS_DATA, v);
        chk(v, 32'hFFFF_FFFF);
        run_op(FIC_CMD_UID, 32'h4, 32'h0);
        rd(FIC_OFS_DATA, v);
        chk(v, UID_BASE | 32'h4);
        slow_answer <= 1'b0;
        $display("test operations done");
        err_case(8'h00, 1'b0, FIC_CMD_PROG, 32'h200, 1'b1);
        err_case(8'h01, 1'b0, FIC_CMD_PROG, 32'h200, 1'b1);
        err_case(8'h09, 1'b0, FIC_CMD_PROG, 32'h200, 1'b0);
        err_case(8'h01, 1'b0, FIC_CMD_PROG, 32'h10_0000, 1'b1);
        err_case(8'h21, 1'b0, FIC_CMD_PROG, 32'h10_0000, 1'b0);
        err_case(8'h21, 1'b1, FIC_CMD_PROG, 32'h10_0000, 1'b1);
        err_case(8'h01, 1'b0, FIC_CMD_PROG, 32'h30_0000, 1'b1);
        err_case(8'h11, 1'b1, FIC_CMD_PROG, 32'h30_0000, 1'b0);
        err_case(8'h01, 1'b0, FIC_CMD_READ, 32'h5_0000, 1'b1);
        err_case(8'h01, 1'b0, 6'h3F, 32'h200, 1'b1);
        $display("test permissions done");
        wr(FIC_OFS_CONTROL, 32'h3);
        chk(boot_select, 1'b1);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk(boot_select, 1'b1);
        // vary the configuration word so its decode is exercised
        for (int i = 0; i < 2; i++) begin
            config_word <= i[0] ? 32'h1790_0000 : 32'h0000_0080;
            power_on_reset <= 1'b1;
            repeat (2) @(posedge clk_sys);
            power_on_reset <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk(boot_select, i[0]);
        end
        $display("test boot_select done");
        final_report();
    end
endmodule
`default_nettype wire
